// ===== clkmon_hs_osc.sv
// behavioural high-speed oscillator with its settle counter
`timescale 1ns/1ns
module clkmon_hs_osc #(
    parameter int SETTLE_NS = 120
) (
    input wire logic i_run,
    input wire logic i_slow,
    input wire logic i_settle_go,
    output logic o_hs_clk,
    output logic o_settle_busy
);
    // a stopped oscillator freezes its pin, the case the monitor must catch
    initial begin
        o_hs_clk = 1'b0;
        forever begin
            // each level spans two samples for the pin filter
            #(i_slow ? 11 : 9);
            if (i_run) begin
                o_hs_clk = ~o_hs_clk;
            end
        end
    end
    initial begin
        o_settle_busy = 1'b0;
        forever begin
            @(posedge i_settle_go);
            o_settle_busy = 1'b1;
            #(SETTLE_NS);
            o_settle_busy = 1'b0;
        end
    end
endmodule

// ===== clkmon_loss_cnt.sv
// counts sampling clocks without high-speed activity
`timescale 1ns/1ns
module clkmon_loss_cnt #(
    parameter int LOSS_CYCLES = clkmon_pkg::CLKMON_LOSS_CYCLES
) (
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic i_active,
    input wire logic i_activity,
    output logic o_lost
);

    localparam int CNT_W = $clog2(LOSS_CYCLES + 1);
    localparam logic [CNT_W-1:0] LAST = CNT_W'(LOSS_CYCLES - 1);

    logic [CNT_W-1:0] idle_count;

    initial begin
        if (LOSS_CYCLES < 1) begin
            $error("LOSS_CYCLES must be at least 1");
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            idle_count <= '0;
            o_lost <= 1'b0;
        end else if (!i_active || i_activity) begin
            idle_count <= '0;
            o_lost <= 1'b0;
        end else if (idle_count == LAST) begin
            idle_count <= '0;
            o_lost <= 1'b1;
        end else begin
            idle_count <= idle_count + CNT_W'(1);
            o_lost <= 1'b0;
        end
    end

endmodule

// ===== clkmon_monitor.sv
// assertion checker on the ports of the clock-loss monitor
`timescale 1ns/1ns
module clkmon_monitor #(
    parameter int LOSS_CYCLES = clkmon_pkg::CLKMON_LOSS_CYCLES
) (
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic i_hs_clk,
    input wire logic i_stop_mode,
    input wire logic [1:0] i_cpu_clk_sel,
    input wire logic i_main_osc_stop_bit,
    input wire logic i_main_clock_halt_bit,
    input wire logic i_ring_osc_stop_bit,
    input wire logic i_option_osc_stoppable,
    input wire logic i_poc_reset,
    input wire logic i_other_int_reset,
    input wire logic o_clock_loss_reset,
    input wire logic o_watch_enable,
    input wire logic o_monitor_active,
    input wire logic o_int_osc_run
);
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);
    logic hs_q;
    logic [3:0] idle_cnt;
    ////////////////////////////////////////////////////////////////
    // raw idle run; always ahead of the design, which sees the pin late
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            hs_q <= 1'b0;
            idle_cnt <= 4'h0;
        end else begin
            hs_q <= i_hs_clk;
            if (i_hs_clk != hs_q) begin
                idle_cnt <= 4'h0;
            end else if (idle_cnt != 4'hF) begin
                idle_cnt <= idle_cnt + 4'h1;
            end
        end
    end
    ////////////////////////////////////////////////////////////////
    property p_loss_clears_enable;
        o_clock_loss_reset |-> !o_watch_enable ##1 !o_clock_loss_reset;
    endproperty
    a_loss_clears_enable: assert property (p_loss_clears_enable) else $error("enable kept at loss");
    property p_loss_from_active;
        $rose(o_clock_loss_reset) |-> $past(o_monitor_active);
    endproperty
    a_loss_from_active: assert property (p_loss_from_active) else $error("loss while not watching");
    property p_loss_min_idle;
        $rose(o_clock_loss_reset) |-> idle_cnt >= LOSS_CYCLES;
    endproperty
    a_loss_min_idle: assert property (p_loss_min_idle) else $error("loss declared too early");
    property p_loss_deadline;
        (o_monitor_active && $stable(i_hs_clk)) [*8] |-> ##[0:4] o_clock_loss_reset;
    endproperty
    a_loss_deadline: assert property (p_loss_deadline) else $error("stopped clock not caught");
    property p_active_needs_enable;
        o_monitor_active |-> o_watch_enable;
    endproperty
    a_active_needs_enable: assert property (p_active_needs_enable) else $error("watching while disabled");
    property p_stop_suspends;
        i_stop_mode [*3] |-> !o_monitor_active;
    endproperty
    a_stop_suspends: assert property (p_stop_suspends) else $error("watching in stop");
    property p_sw_stop_suspends;
        ((i_cpu_clk_sel == 2'h1 && i_main_osc_stop_bit) || (i_cpu_clk_sel == 2'h2 && i_main_clock_halt_bit)) [*3]
            |-> !o_monitor_active;
    endproperty
    a_sw_stop_suspends: assert property (p_sw_stop_suspends) else $error("watching a halted clock");
    property p_ring_suspends;
        (i_ring_osc_stop_bit && i_option_osc_stoppable) [*3] |-> !o_monitor_active && !o_int_osc_run;
    endproperty
    a_ring_suspends: assert property (p_ring_suspends) else $error("watching without sampler");
    property p_ring_locked;
        !i_option_osc_stoppable |=> o_int_osc_run;
    endproperty
    a_ring_locked: assert property (p_ring_locked) else $error("oscillator stopped against option");
    property p_enable_sticky;
        $fell(o_watch_enable) |-> o_clock_loss_reset || $past(i_poc_reset) || $past(i_other_int_reset);
    endproperty
    a_enable_sticky: assert property (p_enable_sticky) else $error("enable cleared without reset");
    c_loss: cover property (o_clock_loss_reset);
    c_active: cover property ($rose(o_monitor_active));
    c_ring: cover property (!o_int_osc_run);
endmodule

bind clkmon_top clkmon_monitor #(.LOSS_CYCLES(LOSS_CYCLES)) chk_u (
    .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_hs_clk(i_hs_clk), .i_stop_mode(i_stop_mode),
    .i_cpu_clk_sel(i_cpu_clk_sel), .i_main_osc_stop_bit(i_main_osc_stop_bit),
    .i_main_clock_halt_bit(i_main_clock_halt_bit), .i_ring_osc_stop_bit(i_ring_osc_stop_bit),
    .i_option_osc_stoppable(i_option_osc_stoppable), .i_poc_reset(i_poc_reset),
    .i_other_int_reset(i_other_int_reset), .o_clock_loss_reset(o_clock_loss_reset),
    .o_watch_enable(o_watch_enable), .o_monitor_active(o_monitor_active), .o_int_osc_run(o_int_osc_run)
);

// ===== clkmon_pkg.sv
// shared constants and types for the clock-loss monitor
package clkmon_pkg;

    // register addresses on the internal data bus
    localparam logic [15:0] CLKMON_ADDR_WATCH_MODE = 16'hFFA9;
    localparam logic [15:0] CLKMON_ADDR_RESET_CAUSE = 16'hFFAC;

    // field positions
    localparam int CLKMON_WATCH_ENABLE_POS = 0;
    localparam int CLKMON_LVI_FLAG_POS = 0;
    localparam int CLKMON_LOSS_FLAG_POS = 1;
    localparam int CLKMON_WDT_FLAG_POS = 4;
    localparam int CLKMON_OSC_STOP_POS = 7;
    localparam int CLKMON_RING_STOP_POS = 0;
    localparam int CLKMON_MAIN_STATUS_POS = 1;

    // values after reset
    localparam logic [7:0] CLKMON_WATCH_MODE_RESET = 8'h00;
    localparam logic [7:0] CLKMON_RESET_CAUSE_RESET = 8'h00;
    localparam logic [7:0] CLKMON_RDATA_RESET = 8'h00;

    // internal oscillator clocks without high-speed activity before a loss
    localparam int CLKMON_LOSS_CYCLES = 4;

    // default settle selection and its length in main-clock cycles
    localparam logic [7:0] CLKMON_SETTLE_SEL_DEFAULT = 8'h05;
    localparam int CLKMON_SETTLE_EXP_DEFAULT = 16;

    // synchroniser depth for pins from other clock domains
    localparam int CLKMON_SYNC_STAGES = 3;

    // clock that the processor runs from
    typedef enum logic [1:0] {
        CLKMON_CPU_MAIN,
        CLKMON_CPU_INTERNAL,
        CLKMON_CPU_SUBSYSTEM
    } clkmon_cpu_clk_t;

    // monitor states
    typedef enum logic [1:0] {
        CLKMON_IDLE,
        CLKMON_SUSPENDED,
        CLKMON_WATCHING,
        CLKMON_FIRED
    } clkmon_state_t;

endpackage

// ===== clkmon_sync3.sv
// three-stage synchroniser with agreement filter and change pulse
`timescale 1ns/1ns
module clkmon_sync3 (
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic i_async,
    output logic o_level,
    output logic o_change
);

    logic stage1;
    logic stage2;
    logic stage3;

    // first stage feeds only the second
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            stage1 <= 1'b0;
            stage2 <= 1'b0;
            stage3 <= 1'b0;
        end else begin
            stage1 <= i_async;
            stage2 <= stage1;
            stage3 <= stage2;
        end
    end

    // a change counts only once stages two and three agree
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_level <= 1'b0;
            o_change <= 1'b0;
        end else begin
            o_change <= (stage2 == stage3) && (stage3 != o_level);
            if (stage2 == stage3) begin
                o_level <= stage3;
            end
        end
    end

endmodule

// ===== clkmon_tb.sv
// self-checking testbench for the clock-loss monitor
`timescale 1ns/1ns
module testbench;
    logic i_ref_clk, i_rst, i_hs_clk, i_wr_byte, i_wr_bit, i_rd, i_stop_mode, i_osc_settle_busy;
    logic i_main_osc_stop_bit, i_main_clock_halt_bit, i_ring_osc_stop_bit, i_option_osc_stoppable, i_halt_mode;
    logic [15:0] i_addr;
    logic [2:0] i_bit_pos;
    logic [7:0] i_wdata, o_rdata;
    logic [1:0] i_cpu_clk_sel;
    logic o_clock_loss_reset, o_watch_enable, o_monitor_active, o_int_osc_run, osc_run, osc_slow, settle_go;
    int error_cnt = 0;
    int comparisons = 0;
    int cyc = 0;
    clkmon_top #(.LOSS_CYCLES(4)) dut_u (
        .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_poc_reset(1'b0), .i_other_int_reset(1'b0),
        .i_wdt_reset_req(1'b0), .i_lvi_reset_req(1'b0), .i_hs_clk(i_hs_clk), .i_addr(i_addr),
        .i_wr_byte(i_wr_byte), .i_wr_bit(i_wr_bit), .i_bit_pos(i_bit_pos), .i_wdata(i_wdata), .i_rd(i_rd),
        .i_stop_mode(i_stop_mode), .i_halt_mode(i_halt_mode), .i_cpu_clk_sel(i_cpu_clk_sel),
        .i_main_osc_stop_bit(i_main_osc_stop_bit), .i_main_clock_halt_bit(i_main_clock_halt_bit),
        .i_ring_osc_stop_bit(i_ring_osc_stop_bit), .i_option_osc_stoppable(i_option_osc_stoppable),
        .i_osc_settle_busy(i_osc_settle_busy), .o_rdata(o_rdata), .o_clock_loss_reset(o_clock_loss_reset),
        .o_watch_enable(o_watch_enable), .o_monitor_active(o_monitor_active), .o_int_osc_run(o_int_osc_run)
    );
    clkmon_hs_osc osc_u (.i_run(osc_run), .i_slow(osc_slow), .i_settle_go(settle_go), .o_hs_clk(i_hs_clk),
        .o_settle_busy(i_osc_settle_busy));
    initial begin
        i_ref_clk = 1'b0;
        forever begin
            #2 i_ref_clk = ~i_ref_clk;
        end
    end
    ////////////////////////////////////////////////////////////////
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic bitw, input logic [2:0] pos);
        @(posedge i_ref_clk);
        i_addr <= a;
        i_wdata <= d;
        i_bit_pos <= pos;
        i_wr_byte <= !bitw;
        i_wr_bit <= bitw;
        @(posedge i_ref_clk);
        i_wr_byte <= 1'b0;
        i_wr_bit <= 1'b0;
    endtask
    task automatic rd(input logic [15:0] a, input logic [7:0] exp);
        @(posedge i_ref_clk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_ref_clk);
        i_rd <= 1'b0;
        #1;
        chk(o_rdata, exp, "read");
    endtask
    // bounded wait; the settle interval alone is about 30 cycles
    task automatic wait_act(input logic exp);
        int n;
        n = 0;
        while (o_monitor_active !== exp && n < 60) begin
            @(posedge i_ref_clk);
            #1;
            n++;
        end
        chk({7'h00, o_monitor_active}, {7'h00, exp}, "active");
    endtask
    task automatic quiet(input int cycles);
        logic seen;
        seen = 1'b0;
        repeat (cycles) begin
            @(posedge i_ref_clk);
            #1;
            seen |= (o_clock_loss_reset !== 1'b0);
        end
        chk({7'h00, seen}, 8'h00, "loss reset");
    endtask
    task automatic settle();
        @(posedge i_ref_clk);
        settle_go <= 1'b1;
        @(posedge i_ref_clk);
        settle_go <= 1'b0;
    endtask
    ////////////////////////////////////////////////////////////////
    task automatic t_defer();
        rd(16'hFFA9, 8'h00);
        chk({6'h00, o_watch_enable, o_int_osc_run}, 8'h01, "reset outputs");
        settle();
        wr(16'hFFA9, 8'h01, 1'b0, 3'h0);
        #1;
        chk({7'h00, o_monitor_active}, 8'h00, "active in settle");
        wait_act(1'b1);
        $display("defer test done");
    endtask
    task automatic t_reg();
        wr(16'hFFA9, 8'h00, 1'b0, 3'h0);
        wr(16'hFFA9, 8'h00, 1'b1, 3'h0);
        rd(16'hFFA9, 8'h01);
        wr(16'hFFA9, 8'hFF, 1'b0, 3'h0);
        wr(16'hFFA9, 8'h01, 1'b1, 3'h5);
        rd(16'hFFA9, 8'h01);
        wr(16'hFFAC, 8'hFF, 1'b0, 3'h0);
        rd(16'hFFAC, 8'h00);
        rd(16'h1234, 8'h00);
        $display("register test done");
    endtask
    // internal and subsystem cpu clock sources: the foreign bit must not suspend, its own must
    task automatic t_sw_stop();
        for (int sel = 1; sel <= 2; sel++) begin
            @(posedge i_ref_clk);
            i_cpu_clk_sel <= 2'(sel);
            i_main_osc_stop_bit <= (sel == 2);
            i_main_clock_halt_bit <= (sel == 1);
            repeat (8) @(posedge i_ref_clk);
            wait_act(1'b1);
            i_main_osc_stop_bit <= (sel == 1);
            i_main_clock_halt_bit <= (sel == 2);
            osc_run <= 1'b0;
            wait_act(1'b0);
            quiet(30);
            @(posedge i_ref_clk);
            i_main_osc_stop_bit <= 1'b0;
            i_main_clock_halt_bit <= 1'b0;
            osc_run <= 1'b1;
            settle();
            wait_act(1'b1);
        end
        $display("software stop test done");
    endtask
    task automatic t_stop();
        @(posedge i_ref_clk);
        i_stop_mode <= 1'b1;
        osc_run <= 1'b0;
        wait_act(1'b0);
        quiet(30);
        @(posedge i_ref_clk);
        i_stop_mode <= 1'b0;
        osc_run <= 1'b1;
        settle();
        wait_act(1'b1);
        @(posedge i_ref_clk);
        i_halt_mode <= 1'b1;
        repeat (6) @(posedge i_ref_clk);
        #1;
        chk({7'h00, o_monitor_active}, 8'h01, "halt running");
        @(posedge i_ref_clk);
        i_halt_mode <= 1'b0;
        $display("stop test done");
    endtask
    task automatic t_ring();
        @(posedge i_ref_clk);
        i_ring_osc_stop_bit <= 1'b1;
        repeat (6) @(posedge i_ref_clk);
        #1;
        chk({6'h00, o_int_osc_run, o_monitor_active}, 8'h03, "ring locked");
        @(posedge i_ref_clk);
        i_option_osc_stoppable <= 1'b1;
        wait_act(1'b0);
        chk({7'h00, o_int_osc_run}, 8'h00, "ring stop");
        @(posedge i_ref_clk);
        i_ring_osc_stop_bit <= 1'b0;
        wait_act(1'b1);
        $display("ring test done");
    endtask
    task automatic t_loss();
        int n;
        n = 0;
        @(posedge i_ref_clk);
        osc_slow <= 1'b1;
        quiet(40);
        chk({7'h00, o_monitor_active}, 8'h01, "slow clock");
        @(posedge i_ref_clk);
        osc_run <= 1'b0;
        while (o_clock_loss_reset !== 1'b1 && n < 30) begin
            @(posedge i_ref_clk);
            #1;
            n++;
        end
        chk({7'h00, o_clock_loss_reset}, 8'h01, "loss fired");
        chk({7'h00, n >= 4}, 8'h01, "loss delay");
        chk({7'h00, o_watch_enable}, 8'h00, "enable at loss");
        rd(16'hFFAC, 8'h02);
        rd(16'hFFAC, 8'h00);
        rd(16'hFFA9, 8'h00);
        $display("loss test done");
    endtask
    ////////////////////////////////////////////////////////////////
    task automatic print_verdict();
        $display("comparisons %0d, mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    always @(posedge i_ref_clk) begin
        cyc++;
        if (cyc == 5000) begin
            error_cnt++;
            $display("unexpected at %0t: run hung", $time);
            print_verdict();
        end
    end
    initial begin
        {i_wr_byte, i_wr_bit, i_rd, i_stop_mode, i_main_osc_stop_bit, i_main_clock_halt_bit, i_halt_mode} = 7'h00;
        {i_ring_osc_stop_bit, i_option_osc_stoppable, osc_slow, settle_go} = 4'h0;
        i_addr = 16'h0000;
        i_bit_pos = 3'h0;
        i_wdata = 8'h00;
        i_cpu_clk_sel = 2'h0;
        osc_run = 1'b1;
        i_rst = 1'b1;
        repeat (20) @(posedge i_ref_clk);
        i_rst <= 1'b0;
        t_defer();
        t_reg();
        t_sw_stop();
        t_stop();
        t_ring();
        t_loss();
        print_verdict();
    end
endmodule

// ===== clkmon_top.sv
// clock-loss monitor: watch register, reset-cause flags, loss detection
//
// Behaviour
// - sample high-speed clock, reset when it stops
// - four idle sampling clocks declare a loss
// - loss reset sets cause flag bit 1
// - enable bit 0 starts monitoring
// - suspended during post-reset settle interval
// - suspended in STOP and following settle
// - suspended while software stops high-speed clock
// - suspended while internal oscillator is stopped
// - 8-bit mode register, upper bits zero
// - external reset clears mode register
// - enable is sticky against software zero
// - loss reset clears enable, sets flag
// - enable during settle defers until settled
// - enable after settle starts at once
// - resume after STOP settle automatically
// - resume after software clock stop settles
// - resume once internal oscillator runs again
// - operate in normal run and HALT, clocks running
// - oscillator stop only when option allows
// - stop bit source depends on CPU clock
// - oscillator stop bit void if option forbids
// - cause flags cleared by external and power-on resets and reads
`timescale 1ns/1ns
module clkmon_top #(
    parameter int LOSS_CYCLES = clkmon_pkg::CLKMON_LOSS_CYCLES
) (
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic i_poc_reset,
    input wire logic i_other_int_reset,
    input wire logic i_wdt_reset_req,
    input wire logic i_lvi_reset_req,
    input wire logic i_hs_clk,
    input wire logic [15:0] i_addr,
    input wire logic i_wr_byte,
    input wire logic i_wr_bit,
    input wire logic [2:0] i_bit_pos,
    input wire logic [7:0] i_wdata,
    input wire logic i_rd,
    input wire logic i_stop_mode,
    input wire logic i_halt_mode,
    input wire logic [1:0] i_cpu_clk_sel,
    input wire logic i_main_osc_stop_bit,
    input wire logic i_main_clock_halt_bit,
    input wire logic i_ring_osc_stop_bit,
    input wire logic i_option_osc_stoppable,
    input wire logic i_osc_settle_busy,
    output logic [7:0] o_rdata,
    output logic o_clock_loss_reset,
    output logic o_watch_enable,
    output logic o_monitor_active,
    output logic o_int_osc_run
);

    initial begin
        if (LOSS_CYCLES < 1 || LOSS_CYCLES > 255) begin
            $error("LOSS_CYCLES out of range");
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // helpers

    // true when a write of either width reaches the given bit of a register
    function automatic logic bit_written(
        input logic [15:0] addr,
        input logic [15:0] reg_addr,
        input logic wr_byte,
        input logic wr_bit,
        input logic [2:0] pos,
        input int field
    );
        logic hit;
        hit = (addr == reg_addr);
        bit_written = hit && (wr_byte || (wr_bit && (pos == 3'(field))));
    endfunction

    // value carried by that write for the given bit
    function automatic logic bit_value(
        input logic wr_byte,
        input logic [7:0] wdata,
        input int field
    );
        logic val;
        val = wr_byte ? wdata[field] : wdata[0];
        bit_value = val;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // pin inputs from other clock domains

    logic hs_level;
    logic hs_change;
    logic settle_busy;
    logic settle_change;

    // high-speed clock is only ever sampled, never used as a clock
    clkmon_sync3 u_hs_sync (
        .i_ref_clk(i_ref_clk),
        .i_rst(i_rst),
        .i_async(i_hs_clk),
        .o_level(hs_level),
        .o_change(hs_change)
    );

    // settle counter runs on the main clock, so it is synchronised too
    clkmon_sync3 u_settle_sync (
        .i_ref_clk(i_ref_clk),
        .i_rst(i_rst),
        .i_async(i_osc_settle_busy),
        .o_level(settle_busy),
        .o_change(settle_change)
    );

    ////////////////////////////////////////////////////////////////////////
    // clock stop conditions

    clkmon_pkg::clkmon_cpu_clk_t cpu_clk;
    logic sw_hs_stop;
    logic ring_stop;
    logic need_suspend;

    assign cpu_clk = clkmon_pkg::clkmon_cpu_clk_t'(i_cpu_clk_sel);

    // which stop bit counts follows the processor's clock source
    always_comb begin
        unique case (cpu_clk)
            clkmon_pkg::CLKMON_CPU_INTERNAL: sw_hs_stop = i_main_osc_stop_bit;
            clkmon_pkg::CLKMON_CPU_SUBSYSTEM: sw_hs_stop = i_main_clock_halt_bit;
            default: sw_hs_stop = 1'b0;
        endcase
    end

    // stop request has no effect unless the option allows it
    assign ring_stop = i_ring_osc_stop_bit && i_option_osc_stoppable;

    // halt is only harmful when a needed clock is gone
    assign need_suspend = i_stop_mode
        || sw_hs_stop
        || ring_stop
        || (i_halt_mode && (sw_hs_stop || ring_stop));

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_int_osc_run <= 1'b1;
        end else begin
            o_int_osc_run <= !ring_stop;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // settle interval tracking

    // wait lasts until the settle counter has been seen busy, then idle;
    // a counter that never reports busy keeps the monitor parked
    logic settle_wait;
    logic settle_seen;
    logic loss_fire;
    logic int_reset;

    assign int_reset = loss_fire || i_other_int_reset || i_poc_reset;

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            settle_wait <= 1'b1;
            settle_seen <= 1'b0;
        end else if (int_reset || i_stop_mode || sw_hs_stop) begin
            settle_wait <= 1'b1;
            settle_seen <= 1'b0;
        end else if (settle_busy) begin
            settle_seen <= 1'b1;
        end else if (settle_seen && settle_change) begin
            settle_wait <= 1'b0;
            settle_seen <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // watch mode register

    logic watch_enable;
    logic enable_wr;
    logic enable_val;

    assign enable_wr = bit_written(i_addr, clkmon_pkg::CLKMON_ADDR_WATCH_MODE, i_wr_byte, i_wr_bit,
        i_bit_pos, clkmon_pkg::CLKMON_WATCH_ENABLE_POS);
    assign enable_val = bit_value(i_wr_byte, i_wdata, clkmon_pkg::CLKMON_WATCH_ENABLE_POS);

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            watch_enable <= clkmon_pkg::CLKMON_WATCH_MODE_RESET[clkmon_pkg::CLKMON_WATCH_ENABLE_POS];
        end else if (int_reset) begin
            watch_enable <= 1'b0;
        end else if (enable_wr && enable_val) begin
            watch_enable <= 1'b1;
        end
        // writes of zero fall through and leave the bit set
    end

    assign o_watch_enable = watch_enable;

    ////////////////////////////////////////////////////////////////////////
    // monitor state

    clkmon_pkg::clkmon_state_t state;
    clkmon_pkg::clkmon_state_t next_state;
    logic suspended;

    assign suspended = settle_wait || need_suspend;

    always_comb begin
        next_state = state;
        unique case (state)
            clkmon_pkg::CLKMON_IDLE: begin
                if (watch_enable) begin
                    next_state = suspended ? clkmon_pkg::CLKMON_SUSPENDED
                        : clkmon_pkg::CLKMON_WATCHING;
                end
            end
            clkmon_pkg::CLKMON_SUSPENDED: begin
                if (!watch_enable) begin
                    next_state = clkmon_pkg::CLKMON_IDLE;
                end else if (!suspended) begin
                    next_state = clkmon_pkg::CLKMON_WATCHING;
                end
            end
            clkmon_pkg::CLKMON_WATCHING: begin
                if (loss_fire) begin
                    next_state = clkmon_pkg::CLKMON_FIRED;
                end else if (!watch_enable) begin
                    next_state = clkmon_pkg::CLKMON_IDLE;
                end else if (suspended) begin
                    next_state = clkmon_pkg::CLKMON_SUSPENDED;
                end
            end
            clkmon_pkg::CLKMON_FIRED: begin
                next_state = clkmon_pkg::CLKMON_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            state <= clkmon_pkg::CLKMON_IDLE;
        end else if (i_poc_reset || i_other_int_reset) begin
            state <= clkmon_pkg::CLKMON_IDLE;
        end else begin
            state <= next_state;
        end
    end

    logic watching;

    // gate on the live condition so a suspend stops counting at once
    assign watching = (state == clkmon_pkg::CLKMON_WATCHING) && watch_enable && !suspended;

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_monitor_active <= 1'b0;
        end else begin
            o_monitor_active <= (next_state == clkmon_pkg::CLKMON_WATCHING) && !int_reset;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // loss detection

    clkmon_loss_cnt #(
        .LOSS_CYCLES(LOSS_CYCLES)
    ) u_loss_cnt (
        .i_ref_clk(i_ref_clk),
        .i_rst(i_rst),
        .i_active(watching),
        .i_activity(hs_change),
        .o_lost(loss_fire)
    );

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_clock_loss_reset <= 1'b0;
        end else begin
            o_clock_loss_reset <= loss_fire;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // reset cause flags

    logic [7:0] reset_cause_flags;
    logic cause_read;
    logic [7:0] cause_set;

    assign cause_read = i_rd && (i_addr == clkmon_pkg::CLKMON_ADDR_RESET_CAUSE);

    always_comb begin
        cause_set = 8'h00;
        cause_set[clkmon_pkg::CLKMON_LOSS_FLAG_POS] = loss_fire;
        cause_set[clkmon_pkg::CLKMON_WDT_FLAG_POS] = i_wdt_reset_req;
        cause_set[clkmon_pkg::CLKMON_LVI_FLAG_POS] = i_lvi_reset_req;
    end

    // a new cause in the read cycle survives the read clear
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            reset_cause_flags <= clkmon_pkg::CLKMON_RESET_CAUSE_RESET;
        end else if (i_poc_reset) begin
            reset_cause_flags <= clkmon_pkg::CLKMON_RESET_CAUSE_RESET;
        end else if (cause_read) begin
            reset_cause_flags <= cause_set;
        end else begin
            reset_cause_flags <= reset_cause_flags | cause_set;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read port

    logic [7:0] next_rdata;

    always_comb begin
        next_rdata = 8'h00;
        if (i_addr == clkmon_pkg::CLKMON_ADDR_WATCH_MODE) begin
            next_rdata[clkmon_pkg::CLKMON_WATCH_ENABLE_POS] = watch_enable;
        end else if (i_addr == clkmon_pkg::CLKMON_ADDR_RESET_CAUSE) begin
            next_rdata = reset_cause_flags;
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_rdata <= clkmon_pkg::CLKMON_RDATA_RESET;
        end else if (i_rd) begin
            o_rdata <= next_rdata;
        end
    end

endmodule
